// *** rtl/tcp_defs.svh ***
// Register offsets, field positions and reset values of the compare/PWM timer
`ifndef TCP_DEFS_SVH
`define TCP_DEFS_SVH

`define TCP_OFF_SC       12'h000
`define TCP_OFF_CNT      12'h004
`define TCP_OFF_MOD      12'h008
`define TCP_OFF_CH0SC    12'h00c
`define TCP_OFF_CH0VAL   12'h010
`define TCP_OFF_CH1SC    12'h014
`define TCP_OFF_CH1VAL   12'h018
`define TCP_OFF_PINS     12'h01c

`define TCP_SC_OVF       7
`define TCP_SC_OVIE      6
`define TCP_SC_STOP      5
`define TCP_SC_RST       4
`define TCP_SC_PS_LO     0

`define TCP_CH_FLAG      7
`define TCP_CH_IE        6
`define TCP_CH_MSB       5
`define TCP_CH_MSA       4
`define TCP_CH_ELSB      3
`define TCP_CH_ELSA      2
`define TCP_CH_TOV       1
`define TCP_CH_MAX       0

`define TCP_SC_RESET     8'h20
`define TCP_CH_RESET     8'h00
`define TCP_MOD_RESET    16'hffff
`define TCP_PS_EXT       3'h7

`endif

// *** rtl/tcp_pkg.sv ***
// Types shared by the compare/PWM timer files
package tcp_pkg;
   typedef struct packed {
      logic       flag;
      logic       intEn;
      logic       modeHigh;
      logic       modeLow;
      logic       actHigh;
      logic       actLow;
      logic       toggleOnOvf;
      logic       maxDuty;
   } tcp_chctl_s;

   typedef enum logic [1:0] {
      TCP_ACT_NONE,
      TCP_ACT_TOGGLE,
      TCP_ACT_CLEAR,
      TCP_ACT_SET
   } tcp_act_e;
endpackage

// *** rtl/tcp_prescaler.sv ***
// Counter tick generator: bus clock prescaler or synchronised external clock edge
`timescale 1ns/1ns
`default_nettype none
`include "tcp_defs.svh"
module tcp_prescaler
   import tcp_pkg::*;
(
   input  wire logic       clk_sys,
   input  wire logic       rst_b,
   input  wire logic       clear,
   input  wire logic [2:0] sel,
   input  wire logic       extClk,
   output logic            tick
);
   logic [5:0] div_r;
   logic       extS1_r;
   logic       extS2_r;
   logic       extS3_r;
   logic       tickNxt;

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         extS1_r <= 1'b0;
         extS2_r <= 1'b0;
         extS3_r <= 1'b0;
      end else begin
         extS1_r <= extClk;
         extS2_r <= extS1_r;
         extS3_r <= extS2_r;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         div_r <= 6'h00;
      end else if (clear) begin
         div_r <= 6'h00;
      end else begin
         div_r <= div_r + 6'h01;
      end
   end

   // Divide by 2^sel; all-ones selects the rising edge of the external clock
   always_comb begin
      if (sel == `TCP_PS_EXT) begin
         tickNxt = extS2_r & ~extS3_r;
      end else if (sel == 3'h0) begin
         tickNxt = 1'b1;
      end else begin
         tickNxt = ((div_r & ((6'h01 << sel) - 6'h01)) == 6'h00);
      end
   end

   assign tick = tickNxt & ~clear;
endmodule // tcp_prescaler
`default_nettype wire

// *** rtl/tcp_timer.sv ***
// Two-channel 16-bit compare/PWM timer with AHB-Lite register slave
// Operation
// [R1] Capture and compare share one modulo counter
// [R2] Reset leaves channel value registers unchanged
// [R3] Match sets, clears or toggles pin
// [R4] Match raises interrupt when enabled
// [R5] Unbuffered value writes take effect immediately
// [R6] Software shortens width in compare interrupt
// [R7] Software lengthens width in overflow interrupt
// [R8] Buffered bit links channels onto pin 0
// [R9] Channel 0 values control at link start
// [R10] Inactive write takes control at overflow
// [R11] Overflow selects most recently written pair
// [R12] Channel 0 control rules, channel 1 ignored
// [R13] Linked mode releases channel 1 pin
// [R14] Active write acts at once
// [R15] Toggle-on-overflow inverts pin at modulo
// [R16] Period equals modulo plus one ticks
// [R17] Pulse width from overflow to match
// [R18] Software picks action opposite to pulse level
// [R19] Software avoids toggle action for PWM
// [R20] Overflow flag on wrap, interrupt when enabled
// [R21] Channel flag on event, interrupt when enabled
// [R22] Mode and action encodings, buffered overrides
// [R23] No TOV gives 0%, max plus TOV 100%
`timescale 1ns/1ns
`default_nettype none
`include "tcp_defs.svh"
module tcp_timer
   import tcp_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        rst_b,
   input  wire logic        hsel,
   input  wire logic [11:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        extClk,
   input  wire logic [1:0]  chanPinIn,
   output logic [1:0]       chanPinOut,
   output logic [1:0]       chanPinOe,
   output logic             irqReq
);
   // ------------------------------------------------------------
   // Bus slave
   // ------------------------------------------------------------
   logic        wrPend_r;
   logic [11:0] addrQ_r;
   logic        rdEn;
   logic        wrStrobe;
   logic [11:0] wrAddr;
   logic [31:0] rdData;

   assign rdEn = hsel & hready & htrans[1] & ~hwrite;

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         wrPend_r <= 1'b0;
         addrQ_r  <= 12'h000;
      end else if (hready) begin
         wrPend_r <= hsel & htrans[1] & hwrite;
         addrQ_r  <= haddr;
      end
   end

   assign wrStrobe = wrPend_r;
   assign wrAddr   = addrQ_r;

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         hrdata    <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else if (rdEn) begin
         hrdata <= rdData;
      end
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   logic [7:0]  sc_r;
   logic [15:0] mod_r;
   logic [15:0] cnt_r;
   tcp_chctl_s  ch_r [2];
   logic [15:0] val_r [2];
   logic        valInit_r;
   logic [1:0]  pinLvl_r;
   logic [1:0]  capS1_r;
   logic [1:0]  capS2_r;
   logic [1:0]  capS3_r;
   logic        linked;
   logic        activeCh_r;
   logic        lastWr_r;
   logic        linkedQ_r;
   logic        tick;
   logic [15:0] cntNxt;
   logic        wrap;
   logic [1:0]  match;
   logic [1:0]  capEvt;
   logic [1:0]  chEvt;
   logic [1:0]  valWr;
   logic        ovfSet;

   assign linked = ch_r[0].modeHigh; // R8 R22
   assign valWr[0] = wrStrobe && wrAddr == `TCP_OFF_CH0VAL;
   assign valWr[1] = wrStrobe && wrAddr == `TCP_OFF_CH1VAL;

   tcp_prescaler u_pre (
      .clk_sys (clk_sys),
      .rst_b   (rst_b),
      .clear   (sc_r[`TCP_SC_RST] | sc_r[`TCP_SC_STOP]),
      .sel     (sc_r[`TCP_SC_PS_LO +: 3]),
      .extClk  (extClk),
      .tick    (tick)
   );

   // ------------------------------------------------------------
   // Counter
   // ------------------------------------------------------------
   // Counter runs 0..modulo, so a period is modulo plus one ticks
   assign wrap = tick && (cnt_r == mod_r); // R16 R15
   // Compares act as the counter enters a value, so width from overflow is the value
   assign cntNxt = (cnt_r == mod_r) ? 16'h0000 : cnt_r + 16'h0001; // R17

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         cnt_r <= 16'h0000;
      end else if (sc_r[`TCP_SC_RST]) begin
         cnt_r <= 16'h0000;
      end else if (wrap) begin
         cnt_r <= 16'h0000; // R20
      end else if (tick) begin
         cnt_r <= cnt_r + 16'h0001;
      end
   end

   assign ovfSet = wrap;

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         sc_r  <= `TCP_SC_RESET;
         mod_r <= `TCP_MOD_RESET;
      end else begin
         // Reset bit is self clearing; flag set beats software clear
         sc_r[`TCP_SC_RST] <= 1'b0;
         if (wrStrobe && wrAddr == `TCP_OFF_SC) begin
            sc_r[6:0] <= {hwdata[6:4], 1'b0, hwdata[2:0]} | {2'b00, hwdata[4], 4'h0};
            if (!hwdata[`TCP_SC_OVF]) begin
               sc_r[`TCP_SC_OVF] <= 1'b0;
            end
         end
         if (wrStrobe && wrAddr == `TCP_OFF_MOD) begin
            mod_r <= hwdata[15:0];
         end
         if (ovfSet) begin
            sc_r[`TCP_SC_OVF] <= 1'b1; // R20
         end
      end
   end

   // ------------------------------------------------------------
   // Channels
   // ------------------------------------------------------------
   // Value storage has no reset so that system reset keeps its contents
   always_ff @(posedge clk_sys) begin
      for (int i = 0; i < 2; i++) begin
         if (valWr[i]) begin
            val_r[i] <= hwdata[15:0]; // R2 R5 R14
         end else if (capEvt[i]) begin
            val_r[i] <= cnt_r; // R1
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         valInit_r <= 1'b0;
      end else begin
         valInit_r <= 1'b1;
      end
   end

   // Buffered pair: controlling channel moves to last-written at overflow
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         activeCh_r <= 1'b0;
         lastWr_r   <= 1'b0;
         linkedQ_r  <= 1'b0;
      end else begin
         linkedQ_r <= linked;
         if (linked && !linkedQ_r) begin
            activeCh_r <= 1'b0; // R9
            lastWr_r   <= 1'b0;
         end else begin
            if (valWr[1]) begin
               lastWr_r <= 1'b1;
            end else if (valWr[0]) begin
               lastWr_r <= 1'b0;
            end
            if (wrap) begin
               activeCh_r <= valWr[1] ? 1'b1 : (valWr[0] ? 1'b0 : lastWr_r); // R10 R11
            end
         end
      end
   end

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : gChan
         logic     outMode;
         logic     capMode;
         logic     selfOn;
         logic     useVal;
         tcp_act_e act;
         tcp_chctl_s cfg;

         // Channel 1 config is ignored while linked
         assign cfg = (linked && g == 1) ? ch_r[0] : ch_r[g]; // R12
         assign selfOn  = !(linked && g == 1); // R13
         assign outMode = (g == 0 && linked) || (selfOn && cfg.modeLow); // R22
         assign capMode = selfOn && !cfg.modeLow && !cfg.modeHigh
                          && (cfg.actHigh | cfg.actLow);
         assign act = tcp_act_e'({cfg.actHigh, cfg.actLow});
         assign useVal = (g == 0 && linked) ? val_r[activeCh_r] == cntNxt
                                            : val_r[g] == cntNxt;
         assign match[g] = outMode && tick && valInit_r && useVal; // R3 R17
         assign capEvt[g] = capMode && (
            (cfg.actLow  &&  capS2_r[g] && !capS3_r[g]) ||
            (cfg.actHigh && !capS2_r[g] &&  capS3_r[g]));
         assign chEvt[g] = match[g] | capEvt[g];

         always_ff @(posedge clk_sys or negedge rst_b) begin
            if (!rst_b) begin
               capS1_r[g] <= 1'b0;
               capS2_r[g] <= 1'b0;
               capS3_r[g] <= 1'b0;
            end else begin
               capS1_r[g] <= chanPinIn[g];
               capS2_r[g] <= capS1_r[g];
               capS3_r[g] <= capS2_r[g];
            end
         end

         always_ff @(posedge clk_sys or negedge rst_b) begin
            if (!rst_b) begin
               pinLvl_r[g]   <= 1'b0;
               chanPinOut[g] <= 1'b0;
               chanPinOe[g]  <= 1'b0;
            end else begin
               if (outMode && match[g]) begin
                  case (act)
                     TCP_ACT_TOGGLE: pinLvl_r[g] <= ~pinLvl_r[g]; // R3
                     TCP_ACT_CLEAR:  pinLvl_r[g] <= 1'b0;
                     TCP_ACT_SET:    pinLvl_r[g] <= 1'b1;
                     default:        pinLvl_r[g] <= pinLvl_r[g];
                  endcase
               end else if (outMode && wrap && cfg.toggleOnOvf) begin
                  pinLvl_r[g] <= ~pinLvl_r[g]; // R15 R23
               end
               // Max duty with toggle-on-overflow holds the pulse level for the whole period
               if (outMode && cfg.maxDuty && cfg.toggleOnOvf) begin
                  chanPinOut[g] <= (act == TCP_ACT_SET) ? 1'b0 : 1'b1; // R23
               end else begin
                  chanPinOut[g] <= pinLvl_r[g];
               end
               chanPinOe[g] <= outMode && act != TCP_ACT_NONE; // R13
            end
         end

         always_ff @(posedge clk_sys or negedge rst_b) begin
            if (!rst_b) begin
               ch_r[g] <= `TCP_CH_RESET;
            end else begin
               if (wrStrobe && wrAddr == ((g == 0) ? `TCP_OFF_CH0SC : `TCP_OFF_CH1SC)) begin
                  ch_r[g][6:0] <= (g == 1) ? {hwdata[6], 1'b0, hwdata[4:0]} : hwdata[6:0];
                  if (!hwdata[`TCP_CH_FLAG]) begin
                     ch_r[g].flag <= 1'b0;
                  end
               end
               if (chEvt[g] && selfOn) begin
                  ch_r[g].flag <= 1'b1; // R21 R4 R6
               end
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------
   // Read mux and interrupt request
   // ------------------------------------------------------------
   always_comb begin
      case (haddr)
         `TCP_OFF_SC:     rdData = {24'h0, sc_r};
         `TCP_OFF_CNT:    rdData = {16'h0, cnt_r};
         `TCP_OFF_MOD:    rdData = {16'h0, mod_r};
         `TCP_OFF_CH0SC:  rdData = {24'h0, ch_r[0]};
         `TCP_OFF_CH0VAL: rdData = {16'h0, val_r[0]};
         `TCP_OFF_CH1SC:  rdData = {24'h0, ch_r[1]};
         `TCP_OFF_CH1VAL: rdData = {16'h0, val_r[1]};
         `TCP_OFF_PINS:   rdData = {29'h0, activeCh_r, pinLvl_r};
         default:         rdData = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         irqReq <= 1'b0;
      end else begin
         irqReq <= (sc_r[`TCP_SC_OVF] & sc_r[`TCP_SC_OVIE])    // R20 R7
                 | (ch_r[0].flag & ch_r[0].intEn)              // R4 R21
                 | (ch_r[1].flag & ch_r[1].intEn & ~linked);
      end
   end
endmodule // tcp_timer
`default_nettype wire

// *** bench/tcp_timer_monitor.sv ***
// Port-level concurrent checks of the compare/PWM timer
`timescale 1ns/1ns
`default_nettype none
module tcp_timer_monitor
   import tcp_pkg::*;
(
   input wire logic        clk_sys,
   input wire logic        rst_b,
   input wire logic        hsel,
   input wire logic [11:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [2:0]  hsize,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic        extClk,
   input wire logic [1:0]  chanPinIn,
   input wire logic [1:0]  chanPinOut,
   input wire logic [1:0]  chanPinOe,
   input wire logic        irqReq
);
   // ------
   // Bus shadow
   // ------
   logic        apW;
   logic        apR;
   logic        wrPrev;
   logic [11:0] apA;
   logic [7:0]  ctl0R;
   logic [15:0] val0R;
   logic        val0Known = 1'h0;
   wire logic   apNow = hsel & htrans[1] & hready;

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         apW    <= 1'h0;
         apR    <= 1'h0;
         wrPrev <= 1'h0;
         apA    <= 12'h000;
      end else begin
         apW    <= apNow & hwrite;
         apR    <= apNow & ~hwrite;
         wrPrev <= apW;
         apA    <= haddr;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) ctl0R <= 8'h00;
      else if (apW && apA == 12'h00c) ctl0R <= hwdata[7:0];
   end

   // No reset here: the value register must outlive one
   always_ff @(posedge clk_sys) begin
      if (apW && apA == 12'h010) begin
         val0R     <= hwdata[15:0];
         val0Known <= 1'h1;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);

   sequence sLinked3;
      ctl0R[5] [*3];
   endsequence
   sequence sDrive3;
      ((ctl0R[5] | ctl0R[4]) && ctl0R[3:2] != 2'h0) [*3];
   endsequence

   AST_BUS_READY: assert property (hreadyout) else $error("ready dropped");
   AST_BUS_OKAY: assert property (!hresp) else $error("error response");
   AST_RESET_QUIET: assert property ($rose(rst_b) |-> chanPinOut == 2'h0 && !irqReq)
      else $error("outputs active after reset");
   AST_LINK_FREES_PIN1: assert property (sLinked3 |-> !chanPinOe[1])
      else $error("pin 1 driven while linked");
   AST_CH0_DRIVES: assert property (sDrive3 |-> chanPinOe[0])
      else $error("pin 0 not driven");
   AST_IRQ_CLEARS_BY_WRITE: assert property ($fell(irqReq) |-> wrPrev || $past(wrPrev) || $past(wrPrev, 2))
      else $error("irq dropped without a write");
   AST_UNMAPPED_ZERO: assert property (apR && apA[11:5] != 7'h00 |-> hrdata == 32'h0)
      else $error("unmapped read not zero");
   AST_VALUE_KEPT: assert property (apR && apA == 12'h010 && val0Known |-> hrdata[15:0] == val0R)
      else $error("channel value lost");
endmodule // tcp_timer_monitor

bind tcp_timer tcp_timer_monitor i_mon (
   .clk_sys(clk_sys), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
   .hreadyout(hreadyout), .hresp(hresp), .extClk(extClk), .chanPinIn(chanPinIn),
   .chanPinOut(chanPinOut), .chanPinOe(chanPinOe), .irqReq(irqReq));
`default_nettype wire

// *** bench/tcp_timer_bench.sv ***
// Self-checking bench for the compare/PWM timer
`timescale 1ns/1ns
`default_nettype none
module tcp_timer_bench;
   logic        clk_sys   = 1'h0;
   logic        rst_b     = 1'h0;
   logic        hsel      = 1'h0;
   logic [11:0] haddr     = 12'h000;
   logic [1:0]  htrans    = 2'h0;
   logic        hwrite    = 1'h0;
   logic [31:0] hwdata    = 32'h0;
   logic        extClk    = 1'h0;
   logic [1:0]  chanPinIn = 2'h0;
   logic [31:0] hrdata, rd;
   logic        hreadyout, hresp, irqReq;
   logic [1:0]  chanPinOut, chanPinOe;
   logic        pinPrev   = 1'h0;
   int          seed      = 8;
   int          failCount = 0;
   int          checked   = 0;
   int          cyc       = 0;
   int          tRise     = 0;
   int          nEdge     = 0;
   int          modVal    = 255;
   int          per, hi, n, v;
   int          runQ [$];
   logic [11:0] rA [7] = '{12'h000, 12'h004, 12'h008, 12'h00c, 12'h014, 12'h01c, 12'h040};
   logic [31:0] rV [7] = '{32'h20, 32'h0, 32'hffff, 32'h0, 32'h0, 32'h0, 32'h0};

   always #25 clk_sys = ~clk_sys;

   tcp_timer i_dut (.clk_sys(clk_sys), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .extClk(extClk),
      .chanPinIn(chanPinIn), .chanPinOut(chanPinOut), .chanPinOe(chanPinOe), .irqReq(irqReq));

   // ------
   // Stimulus and pin model
   // ------
   // Pins are noise: a compare channel must ignore them
   always @(posedge clk_sys) {extClk, chanPinIn} <= 3'($random(seed));

   always @(posedge clk_sys) begin
      cyc++;
      if (chanPinOut[0] !== pinPrev) begin
         nEdge++;
         if (chanPinOut[0] === 1'h1) begin
            per = cyc - tRise;
            tRise = cyc;
         end else hi = cyc - tRise;
      end
      pinPrev = chanPinOut[0];
   end

   task automatic stopTest;
      if (failCount == 0 && checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         failCount++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      hsel <= 1'h1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= wr;
      do @(posedge clk_sys); while (hreadyout !== 1'h1);
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk_sys); while (hreadyout !== 1'h1);
      rd = hrdata;
   endtask

   task automatic waitP(input int k);
      repeat (k * (modVal + 1)) @(posedge clk_sys);
   endtask

   // Stale figures are cleared so a dead pin cannot pass
   task automatic pwmChk(input int eHi);
      per = 0;
      hi = 0;
      waitP(3);
      chk(32'(per), 32'(modVal + 1));
      chk(32'(hi), 32'(eHi));
   endtask

   task automatic edgeChk(input int e);
      waitP(1);
      n = nEdge;
      waitP(4);
      chk(32'(nEdge - n), 32'(e));
   endtask

   initial begin
      repeat (40000) @(posedge clk_sys);
      failCount++;
      stopTest;
   end

   // ------
   // Scenarios
   // ------
   initial begin
      repeat (4) @(posedge clk_sys);
      rst_b <= 1'h1;
      for (int i = 0; i < 7; i++) begin
         bus(1'h0, rA[i], 32'h0);
         chk(rd, rV[i]);
      end
      v = {$random(seed)} % 65536;
      bus(1'h1, 12'h010, 32'(v));
      rst_b <= 1'h0;
      repeat (4) @(posedge clk_sys);
      rst_b <= 1'h1;
      bus(1'h0, 12'h010, 32'h0);
      chk(rd, 32'(v));
      bus(1'h1, 12'h000, 32'h30);
      bus(1'h1, 12'h008, 32'(modVal));
      runQ = '{128};
      repeat (3) runQ.push_back({$random(seed)} % 254 + 1);
      foreach (runQ[k]) begin
         bus(1'h1, 12'h010, 32'(runQ[k]));
         bus(1'h1, 12'h00c, k[0] ? 32'h1e : 32'h1a);
         bus(1'h1, 12'h000, 32'h00);
         pwmChk(k[0] ? 256 - runQ[k] : runQ[k]);
      end
      bus(1'h1, 12'h000, 32'h40);
      waitP(1);
      chk({31'h0, irqReq}, 32'h1);
      bus(1'h1, 12'h000, 32'h00);
      waitP(1);
      bus(1'h0, 12'h000, 32'h0);
      chk({30'h0, irqReq, rd[7]}, 32'h1);
      bus(1'h1, 12'h00c, 32'h5a);
      waitP(1);
      bus(1'h0, 12'h00c, 32'h0);
      chk({30'h0, irqReq, rd[7]}, 32'h3);
      bus(1'h1, 12'h00c, 32'h1a);
      repeat (4) @(posedge clk_sys);
      chk({31'h0, irqReq}, 32'h0);
      bus(1'h1, 12'h00c, 32'h18);
      edgeChk(0);
      chk({31'h0, chanPinOut[0]}, 32'h0);
      bus(1'h1, 12'h00c, 32'h1b);
      edgeChk(0);
      chk({31'h0, chanPinOut[0]}, 32'h1);
      bus(1'h1, 12'h00c, 32'h14);
      edgeChk(4);
      bus(1'h1, 12'h010, 32'h28);
      bus(1'h1, 12'h00c, 32'h2a);
      pwmChk(40);
      bus(1'h1, 12'h014, 32'h5c);
      bus(1'h1, 12'h018, 32'hc8);
      bus(1'h0, 12'h01c, 32'h0);
      chk({31'h0, rd[2]}, 32'h0);
      pwmChk(200);
      bus(1'h0, 12'h01c, 32'h0);
      chk({29'h0, rd[2], irqReq, chanPinOe[1]}, 32'h4);
      bus(1'h1, 12'h010, 32'h5a);
      pwmChk(90);
      stopTest;
   end
endmodule // tcp_timer_bench
`default_nettype wire
